// >>> shared/tpp_cfg.svh
// Constants for the port pin block
`ifndef TPP_CFG_SVH
`define TPP_CFG_SVH
`define TPP_LED_BIT 2
`define TPP_MIXED_W 4
`define TPP_PORT_W 8
`define TPP_CLK_PERIOD_NS 40
`define TPP_RST_PULSE_NS 50
`define TPP_RST_PULSE_CYC ((`TPP_RST_PULSE_NS + `TPP_CLK_PERIOD_NS - 1) / `TPP_CLK_PERIOD_NS)
`define TPP_RST_MIXED 4'h0
`define TPP_RST_PORT 8'h00
`define TPP_RST_BIT 1'b0
`endif

// >>> shared/tpp_pkg.sv
// Types for the port pin block
package tpp_pkg;
  typedef enum logic [2:0]
  {
    SEL_MIXED_DIR = 3'b000,
    SEL_MIXED_OUT = 3'b001,
    SEL_MIXED_PULL = 3'b010,
    SEL_INPUT_PULL = 3'b011,
    SEL_BIDIR_DIR = 3'b100,
    SEL_BIDIR_OUT = 3'b101,
    SEL_BIDIR_PULL = 3'b110,
    SEL_PIN_LEVELS = 3'b111
  } tpp_reg_sel_t;

  typedef struct packed
  {
    logic en;
    tpp_reg_sel_t sel;
    logic [7:0] data;
  } tpp_wr_t;

  typedef struct packed
  {
    logic [3:0] mixed;
    logic [7:0] inport;
    logic [7:0] bidir;
  } tpp_pins_t;
endpackage

// >>> rtl/tpp_pin_sampler.sv
// Samples port pin levels on the system clock
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_pin_sampler
(
  input wire logic sys_clk,
  input wire logic int_rst_n,
  input wire logic clk_en,
  input tpp_pkg::tpp_pins_t pins_in,
  output tpp_pkg::tpp_pins_t pins_sampled
);
  import tpp_pkg::*;

  always_ff @(posedge sys_clk)
  begin
    if (!int_rst_n)
    begin
      pins_sampled <= '0;
    end
    else if (clk_en)
    begin
      pins_sampled <= pins_in;
    end
  end

  sample_pins_a: assert property (@(posedge sys_clk) disable iff (!int_rst_n)
    (clk_en && int_rst_n) |=> pins_sampled == $past(pins_in))
    else $error("pin levels not sampled");
endmodule

// >>> rtl/tpp_port_pins.sv
// Pin-level logic of the mixed, input-only and bidirectional ports
`timescale 1ns/1ps
`include "tpp_cfg.svh"
module tpp_port_pins
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ext_reset_n,
  input tpp_pkg::tpp_wr_t wr,
  input tpp_pkg::tpp_reg_sel_t rd_sel,
  output logic [7:0] rd_data,
  input wire logic [7:0] alt_func_en,
  input tpp_pkg::tpp_pins_t pins_in,
  output logic [3:0] mixed_port_pins_o,
  output logic [3:0] mixed_port_oe,
  output logic [3:0] mixed_pullup_en,
  output logic [7:0] input_pullup_en,
  output logic [7:0] bidir_port_pins_o,
  output logic [7:0] bidir_port_oe,
  output logic [7:0] bidir_pullup_en,
  output logic int_reset
);
  import tpp_pkg::*;

  // ----------------------------------------
  // Reset capture
  // ----------------------------------------
  logic ext_meta;
  logic ext_sync;
  logic rst_int;

  // Async set catches short pulses with no clock running
  always_ff @(posedge sys_clk or negedge ext_reset_n)
  begin
    if (!ext_reset_n)
    begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
    end
    else
    begin
      ext_meta <= 1'b0;
      ext_sync <= ext_meta;
    end
  end

  assign rst_int = !rst_n || ext_sync;

  always_ff @(posedge sys_clk)
  begin
    int_reset <= rst_int;
  end

  // ----------------------------------------
  // CPU registers
  // ----------------------------------------
  logic [3:0] mixed_dir;
  logic [3:0] mixed_out;
  logic [3:0] mixed_pull;
  logic input_pull_all;
  logic [7:0] bidir_dir;
  logic [7:0] bidir_out;
  logic [7:0] bidir_pull;
  tpp_pins_t pins_sampled;

  function automatic logic hit(input tpp_wr_t w, input tpp_reg_sel_t s);
    hit = w.en && (w.sel == s);
  endfunction

  always_ff @(posedge sys_clk)
  begin
    if (rst_int)
    begin
      mixed_dir <= `TPP_RST_MIXED;
      mixed_out <= `TPP_RST_MIXED;
      mixed_pull <= `TPP_RST_MIXED;
      input_pull_all <= `TPP_RST_BIT;
      bidir_dir <= `TPP_RST_PORT;
      bidir_out <= `TPP_RST_PORT;
      bidir_pull <= `TPP_RST_PORT;
    end
    else if (clk_en)
    begin
      if (hit(wr, SEL_MIXED_DIR))
        mixed_dir <= wr.data[3:0];
      if (hit(wr, SEL_MIXED_OUT))
        mixed_out <= wr.data[3:0];
      if (hit(wr, SEL_MIXED_PULL))
        mixed_pull <= wr.data[3:0];
      if (hit(wr, SEL_INPUT_PULL))
        input_pull_all <= wr.data[0];
      if (hit(wr, SEL_BIDIR_DIR))
        bidir_dir <= wr.data;
      if (hit(wr, SEL_BIDIR_OUT))
        bidir_out <= wr.data;
      if (hit(wr, SEL_BIDIR_PULL))
        bidir_pull <= wr.data;
    end
  end

  tpp_pin_sampler u_sampler
  (
    .sys_clk(sys_clk),
    .int_rst_n(!rst_int),
    .clk_en(clk_en),
    .pins_in(pins_in),
    .pins_sampled(pins_sampled)
  );

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] next_rd_data;

  always_comb
  begin
    case (rd_sel)
      SEL_MIXED_DIR: next_rd_data = {4'h0, mixed_dir | 4'h4};
      SEL_MIXED_OUT: next_rd_data = {4'h0, mixed_out};
      SEL_MIXED_PULL: next_rd_data = {4'h0, mixed_pull};
      SEL_INPUT_PULL: next_rd_data = {7'h00, input_pull_all};
      SEL_BIDIR_DIR: next_rd_data = bidir_dir;
      SEL_BIDIR_OUT: next_rd_data = bidir_out;
      SEL_BIDIR_PULL: next_rd_data = bidir_pull;
      SEL_PIN_LEVELS: next_rd_data = pins_sampled.inport;
      default: next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst_int)
      rd_data <= 8'h00;
    else if (clk_en)
      rd_data <= next_rd_data;
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  logic [3:0] next_mixed_oe;
  logic [3:0] next_mixed_pull;
  logic [7:0] next_input_pull;
  logic [7:0] next_bidir_pull;

  always_comb
  begin
    next_mixed_oe = mixed_dir;
    next_mixed_oe[`TPP_LED_BIT] = 1'b1;
    next_mixed_pull = mixed_pull & ~next_mixed_oe;
    next_input_pull = {8{input_pull_all}} & ~alt_func_en;
    next_bidir_pull = bidir_pull & ~bidir_dir;
  end

  // Async clear by the reset pin tristates with no clock
  always_ff @(posedge sys_clk or negedge ext_reset_n)
  begin
    if (!ext_reset_n)
    begin
      mixed_port_oe <= 4'h0;
      mixed_pullup_en <= 4'h0;
      input_pullup_en <= 8'h00;
      bidir_port_oe <= 8'h00;
      bidir_pullup_en <= 8'h00;
      mixed_port_pins_o <= 4'h0;
      bidir_port_pins_o <= 8'h00;
    end
    else if (rst_int)
    begin
      mixed_port_oe <= 4'h0;
      mixed_pullup_en <= 4'h0;
      input_pullup_en <= 8'h00;
      bidir_port_oe <= 8'h00;
      bidir_pullup_en <= 8'h00;
      mixed_port_pins_o <= 4'h0;
      bidir_port_pins_o <= 8'h00;
    end
    else if (clk_en)
    begin
      mixed_port_oe <= next_mixed_oe;
      mixed_pullup_en <= next_mixed_pull;
      input_pullup_en <= next_input_pull;
      bidir_port_oe <= bidir_dir;
      bidir_pullup_en <= next_bidir_pull;
      mixed_port_pins_o <= mixed_out;
      bidir_port_pins_o <= bidir_out;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence wr_mixed_pull_s;
    clk_en && !rst_int && hit(wr, SEL_MIXED_PULL);
  endsequence

  sequence quiet_s;
    clk_en && !rst_int && !wr.en;
  endsequence

  led_always_out_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n || !ext_reset_n)
    (clk_en && !rst_int) |=> mixed_port_oe[`TPP_LED_BIT])
    else $error("led sink bit not driven");

  mixed_pull_write_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n || !ext_reset_n)
    (wr_mixed_pull_s ##1 quiet_s) |=>
      mixed_pullup_en == ($past(wr.data[3:0], 2) & ~mixed_port_oe))
    else $error("mixed pull-up not applied");

  input_pull_shared_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n || !ext_reset_n)
    (clk_en && !rst_int) |=>
      input_pullup_en == ({8{$past(input_pull_all)}} & ~$past(alt_func_en)))
    else $error("shared pull-up wrong");

  alt_pull_off_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n || !ext_reset_n)
    (clk_en && (alt_func_en != 8'h00)) |=> (input_pullup_en & $past(alt_func_en)) == 8'h00)
    else $error("pull-up on special pin");

  bidir_pull_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n || !ext_reset_n)
    (clk_en && !rst_int) |=> bidir_pullup_en == ($past(bidir_pull) & ~$past(bidir_dir)))
    else $error("bidir pull-up wrong");

  pins_tristate_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    (!ext_reset_n || rst_int) |=>
      (mixed_port_oe == 4'h0) && (bidir_port_oe == 8'h00) && (input_pullup_en == 8'h00))
    else $error("pins driven in reset");

  ext_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(ext_reset_n) |-> rst_int ##1 (rst_int || !ext_reset_n))
    else $error("reset released early");

  dir_readback_a: assert property (@(posedge sys_clk)
    disable iff (!rst_n || !ext_reset_n)
    (clk_en && !rst_int && rd_sel == SEL_BIDIR_DIR) |=> rd_data == $past(bidir_dir))
    else $error("direction readback wrong");
endmodule

// >>> dv/tpp_board.sv
// Board-side model of the loads on the port pins
`timescale 1ns/1ps
module tpp_board
(
  input wire logic [3:0] mixed_o,
  input wire logic [3:0] mixed_oe,
  input wire logic [3:0] mixed_pu,
  input wire logic [7:0] in_pu,
  input wire logic [7:0] bidir_o,
  input wire logic [7:0] bidir_oe,
  input wire logic [7:0] bidir_pu,
  input wire logic [19:0] ext_en,
  input wire logic [19:0] ext_val,
  output tpp_pkg::tpp_pins_t pins
);
  import tpp_pkg::*;
  logic [19:0] own;
  logic [19:0] pu;
  // Chip drive wins, then board drive, then pull-up, else weak pull-down
  assign own = {mixed_oe, 8'h00, bidir_oe};
  assign pu = {mixed_pu, in_pu, bidir_pu};
  assign pins = (own & {mixed_o, 8'h00, bidir_o}) | (~own & ext_en & ext_val)
    | (~own & ~ext_en & pu);
endmodule

// >>> dv/tiny_mcu_port_pins_tb.sv
// Self-checking bench for the port pin block
`timescale 1ns/1ps
module tiny_mcu_port_pins_tb;
  import tpp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic ext_reset_n = 1'b1;
  tpp_wr_t wr = '0;
  tpp_reg_sel_t rd_sel = SEL_MIXED_DIR;
  logic [7:0] rd_data;
  logic [7:0] alt_func_en = 8'h00;
  tpp_pins_t pins_in;
  logic [3:0] m_o, m_oe, m_pu;
  logic [7:0] i_pu, b_o, b_oe, b_pu;
  logic int_reset;
  logic [19:0] ext_en = 20'h0ff00;
  logic [19:0] ext_val = 20'h0a500;
  int bad_count = 0;
  int check_count = 0;

  always #20 sys_clk = ~sys_clk;

  tpp_port_pins u_tpp_port_pins (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .ext_reset_n(ext_reset_n), .wr(wr), .rd_sel(rd_sel), .rd_data(rd_data),
    .alt_func_en(alt_func_en), .pins_in(pins_in), .mixed_port_pins_o(m_o),
    .mixed_port_oe(m_oe), .mixed_pullup_en(m_pu), .input_pullup_en(i_pu),
    .bidir_port_pins_o(b_o), .bidir_port_oe(b_oe), .bidir_pullup_en(b_pu),
    .int_reset(int_reset));
  tpp_board u_tpp_board (.mixed_o(m_o), .mixed_oe(m_oe), .mixed_pu(m_pu), .in_pu(i_pu),
    .bidir_o(b_o), .bidir_oe(b_oe), .bidir_pu(b_pu), .ext_en(ext_en), .ext_val(ext_val),
    .pins(pins_in));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One write, then let it reach the pin flops
  task automatic wr_reg(input tpp_reg_sel_t sel, input logic [7:0] d);
    wr = '{1'b1, sel, d};
    cyc(1);
    wr.en = 1'b0;
    cyc(3);
  endtask

  // Select a register and compare the registered read data
  task automatic rd_chk(input tpp_reg_sel_t sel, input logic [7:0] exp);
    rd_sel = sel;
    cyc(2);
    chk(rd_data, exp);
  endtask

  task automatic t_reset;
    chk({4'h0, m_oe}, 8'h04);
    chk({4'h0, m_pu}, 8'h00);
    chk(b_oe | b_pu | i_pu, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_mixed;
    wr_reg(SEL_MIXED_PULL, 8'h0f);
    chk({4'h0, m_pu}, 8'h0b);
    wr_reg(SEL_MIXED_OUT, 8'h04);
    wr_reg(SEL_MIXED_DIR, 8'h01);
    chk({4'h0, m_oe}, 8'h05);
    chk({4'h0, m_pu}, 8'h0a);
    chk({4'h0, m_o & m_oe}, 8'h04);
    wr_reg(SEL_MIXED_DIR, 8'h00);
    chk({4'h0, m_oe}, 8'h04);
    $display("test mixed done");
  endtask

  task automatic t_input;
    wr_reg(SEL_INPUT_PULL, 8'h01);
    chk(i_pu, 8'hff);
    alt_func_en = 8'h21;
    cyc(2);
    chk(i_pu, 8'hde);
    alt_func_en = 8'h00;
    wr_reg(SEL_INPUT_PULL, 8'h00);
    chk(i_pu, 8'h00);
    $display("test input done");
  endtask

  task automatic t_bidir;
    wr_reg(SEL_BIDIR_PULL, 8'h5a);
    wr_reg(SEL_BIDIR_OUT, 8'h33);
    wr_reg(SEL_BIDIR_DIR, 8'h0f);
    chk(b_oe, 8'h0f);
    chk(b_pu, 8'h50);
    chk(b_o & b_oe, 8'h03);
    clk_en = 1'b0;
    wr_reg(SEL_BIDIR_DIR, 8'hff);
    clk_en = 1'b1;
    chk(b_oe, 8'h0f);
    $display("test bidir done");
  endtask

  task automatic t_read;
    rd_sel = SEL_PIN_LEVELS;
    cyc(3);
    chk(rd_data, 8'ha5);
    ext_val = 20'h05a00;
    cyc(3);
    chk(rd_data, 8'h5a);
    rd_sel = SEL_BIDIR_DIR;
    cyc(2);
    chk(rd_data, 8'h0f);
    rd_sel = SEL_MIXED_DIR;
    cyc(2);
    chk(rd_data & 8'h0f, 8'h04);
    rd_chk(SEL_MIXED_OUT, 8'h04);
    rd_chk(SEL_MIXED_PULL, 8'h0f);
    rd_chk(SEL_INPUT_PULL, 8'h00);
    rd_chk(SEL_BIDIR_OUT, 8'h33);
    rd_chk(SEL_BIDIR_PULL, 8'h5a);
    $display("test read done");
  endtask

  // Reset pin pulse of two periods while the block is frozen
  task automatic t_ext;
    clk_en = 1'b0;
    ext_reset_n = 1'b0;
    #1;
    chk(b_oe | b_pu | {4'h0, m_oe | m_pu}, 8'h00);
    chk(i_pu | b_o | {4'h0, m_o}, 8'h00);
    cyc(2);
    ext_reset_n = 1'b1;
    clk_en = 1'b1;
    cyc(1);
    chk({7'h00, int_reset}, 8'h01);
    cyc(4);
    chk({7'h00, int_reset}, 8'h00);
    chk(b_oe, 8'h00);
    chk({4'h0, m_oe}, 8'h04);
    $display("test ext reset done");
  endtask

  task automatic close_out;
    $display("checks=%0d bad=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #50000;
    bad_count++;
    close_out();
  end

  initial
  begin
    cyc(4);
    rst_n = 1'b1;
    cyc(3);
    t_reset();
    t_mixed();
    t_input();
    t_bidir();
    t_read();
    t_ext();
    close_out();
  end
endmodule
